// ---- design/ldo_ctrl_pkg.sv ----
// Purpose: Shared constants for the regulator enable and mode decode block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Bit positions and reset values live here so that the bus slave,
//          the decode and any bench agree on one copy.

package ldo_ctrl_pkg;

    // Bus widths.
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;
    localparam logic [ADDR_W-1:0] PINS_OFFSET   = 12'h008;

    // Control register fields.
    localparam int CTRL_W          = 11;
    localparam int CTRL_FE_SW_BIT  = 0;
    localparam int CTRL_RX_EN_BIT  = 1;
    localparam int CTRL_AN_EN_BIT  = 2;
    localparam int CTRL_LV_EN_BIT  = 3;
    localparam int CTRL_BIAS_EN_LO = 4;
    localparam int CTRL_MODE_SRC   = 7;
    localparam int CTRL_BIAS_PS_LO = 8;

    // Front-end switch defaults off, every other bit defaults on.
    localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h7fe;

    // Number of bias regulators sharing one mode-source bit.
    localparam int BIAS_COUNT = 3;

    // Status register fields.
    localparam int STAT_W            = 13;
    localparam int STAT_FE_ON        = 0;
    localparam int STAT_RX_ON        = 1;
    localparam int STAT_RX_NORMAL    = 2;
    localparam int STAT_AN_ON        = 3;
    localparam int STAT_AN_NORMAL    = 4;
    localparam int STAT_LV_ON        = 5;
    localparam int STAT_LV_NORMAL    = 6;
    localparam int STAT_BIAS_ON_LO   = 7;
    localparam int STAT_BIAS_NORM_LO = 10;

    // Pin snapshot register fields.
    localparam int PINS_W            = 5;
    localparam int PIN_MASTER_EN     = 0;
    localparam int PIN_IO_PRESENT    = 1;
    localparam int PIN_CHIP_RESET_N  = 2;
    localparam int PIN_RADIO_ON      = 3;
    localparam int PIN_SEC_CLK_EN    = 4;

    // Register select produced by the address decode.
    typedef enum logic [1:0] {
        SEL_CTRL   = 2'b00,
        SEL_STATUS = 2'b01,
        SEL_PINS   = 2'b10,
        SEL_NONE   = 2'b11
    } reg_sel_t;

endpackage : ldo_ctrl_pkg

// ---- design/ldo_bias_mode_sel.sv ----
// Purpose: On/off and normal/low-power decode for one bias regulator.
// Assumes: All inputs are settled levels in the core clock domain.
// Notes:   Purely combinational; the parent registers both results.

`timescale 1ns/100ps

module ldo_bias_mode_sel (
    // Supply and pin state.
    input  wire logic master_en,
    input  wire logic io_supply_present,
    input  wire logic secondary_clock_enable_pin,
    // Register bits.
    input  wire logic enable_bit,
    input  wire logic bias_mode_source_bit,
    input  wire logic powersave_bit,
    // Decoded regulator state.
    output logic      reg_on,
    output logic      reg_normal
);

    // Off needs only master enable or the enable bit low; the IO supply
    // does not gate these rails, it only pins them to normal mode.
    always_comb begin
        reg_on     = master_en & enable_bit;
        reg_normal = 1'b0;
        if (reg_on) begin
            if (!io_supply_present) begin
                reg_normal = 1'b1;
            end else if (bias_mode_source_bit) begin
                reg_normal = powersave_bit;
            end else begin
                reg_normal = secondary_clock_enable_pin;
            end
        end
    end

endmodule : ldo_bias_mode_sel

// ---- design/ldo_enable_mode_decode.sv ----
// Purpose: Enable and mode decode for the front-end load switch and six
//          regulators, with the control bits held in an APB register file.
// Assumes: Pins are synchronous to core_clk; APB master is well behaved.
// Notes:   Outputs are registered, so they follow pins and bits one cycle
//          late; the analog rails settle far slower than that.
//
// How it works
// - Front-end switch on only with master, IO, radio, receive and switch bits.
// - Front-end switch enable bit is software writable, resets to 0.
// - Analog regulator follows its bit; radio pin picks normal or low power.
// - Analog regulator enable bit is software writable, resets to 1.
// - Chip reset low forces the enabled analog regulator to normal mode.
// - Low-voltage regulator follows its bit; radio pin picks its mode.
// - Low-voltage regulator enable bit is software writable, resets to 1.
// - Low-voltage regulator off without master or IO; chip reset forces normal.
// - Bias A mode from its power-save bit or secondary clock pin.
// - Bias A enable, mode source and power-save bits writable, reset 1.
// - Bias rails off without master or bit; IO absent forces normal.
// - Bias B uses the same selection with its own bits.
// - Bias B enable, mode source and power-save bits writable, reset 1.
// - Bias C mode from its power-save bit or secondary clock pin.
// - Bias C enable, mode source and power-save bits writable, reset 1.
// - Receive regulator enable bit is software writable, resets to 1.
//
// Our own choices: register access over APB and the register offsets.

`timescale 1ns/100ps

module ldo_enable_mode_decode (
    // Clock, reset and clock enable.
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire logic                          clk_en,
    // APB slave.
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ldo_ctrl_pkg::ADDR_W-1:0] paddr,
    input  wire logic [ldo_ctrl_pkg::DATA_W-1:0] pwdata,
    output logic      [ldo_ctrl_pkg::DATA_W-1:0] prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Control pins from the host.
    input  wire logic                          master_en,
    input  wire logic                          io_supply_present,
    input  wire logic                          chip_reset_n,
    input  wire logic                          radio_on_pin,
    input  wire logic                          secondary_clock_enable_pin,
    // Front-end load switch.
    output logic                               frontend_switch_output,
    // Receive regulator.
    output logic                               receive_regulator_on,
    output logic                               receive_regulator_normal,
    // Analog regulator.
    output logic                               analog_regulator_on,
    output logic                               analog_regulator_normal,
    // Low-voltage regulator.
    output logic                               low_voltage_regulator_on,
    output logic                               low_voltage_regulator_normal,
    // Bias regulators, bit 0 is regulator A, bit 2 is regulator C.
    output logic      [ldo_ctrl_pkg::BIAS_COUNT-1:0] bias_regulator_on,
    output logic      [ldo_ctrl_pkg::BIAS_COUNT-1:0] bias_regulator_normal
);

    import ldo_ctrl_pkg::*;

    // Address decode shared by the read path and the write strobe.
    function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (addr == CTRL_OFFSET) begin
            sel = SEL_CTRL;
        end else if (addr == STATUS_OFFSET) begin
            sel = SEL_STATUS;
        end else if (addr == PINS_OFFSET) begin
            sel = SEL_PINS;
        end
        return sel;
    endfunction : decode_addr

    // A supply-gated rail is on only with master enable, IO supply and bit.
    function automatic logic rail_on(input logic master,
                                     input logic io_ok,
                                     input logic en_bit);
        return master & io_ok & en_bit;
    endfunction : rail_on

    // Mode of a radio-steered rail; chip reset overrides the radio pin.
    function automatic logic rail_normal(input logic on,
                                         input logic crst_n,
                                         input logic radio);
        return on & (~crst_n | radio);
    endfunction : rail_normal

    // Register and output state.
    logic [CTRL_W-1:0]     ctrl_q;
    logic [DATA_W-1:0]     prdata_q;
    logic [DATA_W-1:0]     prdata_d;
    logic                  pready_q;
    logic                  pslverr_q;
    logic                  fe_on_q;
    logic                  rx_on_q;
    logic                  rx_normal_q;
    logic                  an_on_q;
    logic                  an_normal_q;
    logic                  lv_on_q;
    logic                  lv_normal_q;
    logic [BIAS_COUNT-1:0] bias_on_q;
    logic [BIAS_COUNT-1:0] bias_normal_q;

    // Combinational helpers.
    reg_sel_t              sel;
    logic                  setup_phase;
    logic                  wr_ctrl;
    logic                  ctrl_reset_cond;
    logic                  fe_on_d;
    logic                  rx_on_d;
    logic                  rx_normal_d;
    logic                  an_on_d;
    logic                  an_normal_d;
    logic                  lv_on_d;
    logic                  lv_normal_d;
    logic [BIAS_COUNT-1:0] bias_on_d;
    logic [BIAS_COUNT-1:0] bias_normal_d;
    logic [STAT_W-1:0]     status_vec;
    logic [PINS_W-1:0]     pins_vec;

    // Bus phase decode. The answer is prepared in the setup cycle so that
    // pready can come from a flop and still give a zero-wait access.
    assign sel         = decode_addr(paddr);
    assign setup_phase = psel & ~penable;
    assign wr_ctrl     = psel & penable & pready_q & pwrite & (sel == SEL_CTRL);

    // Losing the master enable or holding chip reset puts every bit back to
    // its default; software writes are ignored for as long as that lasts.
    assign ctrl_reset_cond = ~master_en | ~chip_reset_n;

    // Control register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (clk_en) begin
            if (ctrl_reset_cond) begin
                ctrl_q <= CTRL_RESET;
            end else if (wr_ctrl) begin
                ctrl_q <= pwdata[CTRL_W-1:0];
            end
        end
    end

    // Front-end switch needs the receive regulator bit as well as its own.
    assign fe_on_d = rail_on(master_en, io_supply_present, radio_on_pin)
                   & ctrl_q[CTRL_RX_EN_BIT] & ctrl_q[CTRL_FE_SW_BIT];

    // Receive regulator, same gating and mode choice as the analog rail.
    assign rx_on_d     = rail_on(master_en, io_supply_present, ctrl_q[CTRL_RX_EN_BIT]);
    assign rx_normal_d = rail_normal(rx_on_d, chip_reset_n, radio_on_pin);

    // Analog regulator.
    assign an_on_d     = rail_on(master_en, io_supply_present,
                                 ctrl_q[CTRL_AN_EN_BIT]);
    assign an_normal_d = rail_normal(an_on_d, chip_reset_n, radio_on_pin);

    // Low-voltage regulator.
    assign lv_on_d     = rail_on(master_en, io_supply_present,
                                 ctrl_q[CTRL_LV_EN_BIT]);
    assign lv_normal_d = rail_normal(lv_on_d, chip_reset_n, radio_on_pin);

    // One decode per bias regulator; they share only the mode-source bit.
    generate
        for (genvar i = 0; i < BIAS_COUNT; i++) begin : g_bias
            ldo_bias_mode_sel u_bias (
                .master_en                  (master_en),
                .io_supply_present          (io_supply_present),
                .secondary_clock_enable_pin (secondary_clock_enable_pin),
                .enable_bit                 (ctrl_q[CTRL_BIAS_EN_LO + i]),
                .bias_mode_source_bit       (ctrl_q[CTRL_MODE_SRC]),
                .powersave_bit              (ctrl_q[CTRL_BIAS_PS_LO + i]),
                .reg_on                     (bias_on_d[i]),
                .reg_normal                 (bias_normal_d[i])
            );
        end
    endgenerate

    // Registered rail outputs. One cycle of lag is the price of driving
    // every pin from a flop; it keeps decode glitches off the analog enables.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fe_on_q       <= 1'b0;
            rx_on_q       <= 1'b0;
            rx_normal_q   <= 1'b0;
            an_on_q       <= 1'b0;
            an_normal_q   <= 1'b0;
            lv_on_q       <= 1'b0;
            lv_normal_q   <= 1'b0;
            bias_on_q     <= '0;
            bias_normal_q <= '0;
        end else if (clk_en) begin
            fe_on_q       <= fe_on_d;
            rx_on_q       <= rx_on_d;
            rx_normal_q   <= rx_normal_d;
            an_on_q       <= an_on_d;
            an_normal_q   <= an_normal_d;
            lv_on_q       <= lv_on_d;
            lv_normal_q   <= lv_normal_d;
            bias_on_q     <= bias_on_d;
            bias_normal_q <= bias_normal_d;
        end
    end

    // Status view of what the pins are being driven to right now.
    always_comb begin
        status_vec                                           = '0;
        status_vec[STAT_FE_ON]                               = fe_on_q;
        status_vec[STAT_RX_ON]                               = rx_on_q;
        status_vec[STAT_RX_NORMAL]                           = rx_normal_q;
        status_vec[STAT_AN_ON]                               = an_on_q;
        status_vec[STAT_AN_NORMAL]                           = an_normal_q;
        status_vec[STAT_LV_ON]                               = lv_on_q;
        status_vec[STAT_LV_NORMAL]                           = lv_normal_q;
        status_vec[STAT_BIAS_ON_LO +: BIAS_COUNT]            = bias_on_q;
        status_vec[STAT_BIAS_NORM_LO +: BIAS_COUNT]          = bias_normal_q;
    end

    // Pin snapshot, handy for checking the host side wiring.
    always_comb begin
        pins_vec                   = '0;
        pins_vec[PIN_MASTER_EN]    = master_en;
        pins_vec[PIN_IO_PRESENT]   = io_supply_present;
        pins_vec[PIN_CHIP_RESET_N] = chip_reset_n;
        pins_vec[PIN_RADIO_ON]     = radio_on_pin;
        pins_vec[PIN_SEC_CLK_EN]   = secondary_clock_enable_pin;
    end

    // Read mux; unused upper bits read as zero.
    always_comb begin
        prdata_d = '0;
        unique case (sel)
            SEL_CTRL: begin
                prdata_d[CTRL_W-1:0] = ctrl_q;
            end
            SEL_STATUS: begin
                prdata_d[STAT_W-1:0] = status_vec;
            end
            SEL_PINS: begin
                prdata_d[PINS_W-1:0] = pins_vec;
            end
            SEL_NONE: begin
                prdata_d = '0;
            end
        endcase
    end

    // APB answer. Setup loads the answer, the access edge completes it and
    // drops pready, so a back-to-back setup can reload at once.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else if (clk_en) begin
            pready_q <= setup_phase;
            if (setup_phase) begin
                pslverr_q <= (sel == SEL_NONE);
                prdata_q  <= pwrite ? '0 : prdata_d;
            end else begin
                pslverr_q <= 1'b0;
                prdata_q  <= '0;
            end
        end
    end

    // Port drivers, all straight from flops.
    assign prdata                       = prdata_q;
    assign pready                       = pready_q;
    assign pslverr                      = pslverr_q;
    assign frontend_switch_output       = fe_on_q;
    assign receive_regulator_on         = rx_on_q;
    assign receive_regulator_normal     = rx_normal_q;
    assign analog_regulator_on          = an_on_q;
    assign analog_regulator_normal      = an_normal_q;
    assign low_voltage_regulator_on     = lv_on_q;
    assign low_voltage_regulator_normal = lv_normal_q;
    assign bias_regulator_on            = bias_on_q;
    assign bias_regulator_normal        = bias_normal_q;

endmodule : ldo_enable_mode_decode

// ---- bench/ldo_decode_assertions.sv ----
// Purpose: Port-level checks for the regulator enable and mode decode.
// Assumes: Rail outputs lag the pins by one enabled clock edge.
// Notes:   Control bits are not visible here, so checks lean on the pins.

`timescale 1ns/100ps

module ldo_decode_assertions (
    // Clock, reset and enable.
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       clk_en,
    // Bus handshake.
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    // Host pins.
    input wire logic       master_en,
    input wire logic       io_supply_present,
    input wire logic       chip_reset_n,
    input wire logic       radio_on_pin,
    // Rails.
    input wire logic       frontend_switch_output,
    input wire logic       receive_regulator_on,
    input wire logic       analog_regulator_on,
    input wire logic       analog_regulator_normal,
    input wire logic       low_voltage_regulator_on,
    input wire logic       low_voltage_regulator_normal,
    input wire logic [2:0] bias_regulator_on,
    input wire logic [2:0] bias_regulator_normal
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // A setup cycle is one enabled edge with select up and enable still down.
    sequence setup_s;
        psel && !penable && clk_en;
    endsequence
    sequence access_s;
        pready && clk_en;
    endsequence

    a_fe_gated: assert property (frontend_switch_output && $past(clk_en) |->
        $past(master_en && io_supply_present && radio_on_pin)) else $error("switch on without pins");
    a_rx_supply: assert property (receive_regulator_on && $past(clk_en) |->
        $past(master_en && io_supply_present)) else $error("receive rail on without supply");
    a_an_forced: assert property ($past(clk_en && !chip_reset_n) && analog_regulator_on
        |-> analog_regulator_normal) else $error("analog rail not forced normal");
    a_an_lowpower: assert property ($past(clk_en && chip_reset_n && !radio_on_pin)
        |-> !analog_regulator_normal) else $error("analog rail not low power");
    a_lv_off: assert property ($past(clk_en && !(master_en && io_supply_present))
        |-> !low_voltage_regulator_on) else $error("low voltage rail not off");
    a_lv_mode: assert property ($past(clk_en && chip_reset_n) && low_voltage_regulator_on
        |-> low_voltage_regulator_normal == $past(radio_on_pin)) else $error("low voltage mode");
    a_bias_off: assert property ($past(clk_en && !master_en)
        |-> bias_regulator_on == 3'h0) else $error("bias rails not off");
    a_bias_io_norm: assert property ($past(clk_en && !io_supply_present)
        |-> bias_regulator_normal == bias_regulator_on) else $error("bias not forced normal");
    a_bias_mode_on: assert property ((bias_regulator_normal & ~bias_regulator_on) == 3'h0)
        else $error("bias normal while off");
    a_apb_answer: assert property (setup_s |=> pready) else $error("no answer after setup");
    a_apb_once: assert property (access_s |=> !pready) else $error("answer stands too long");
    a_freeze_hold: assert property (!$past(clk_en) |-> $stable({pready,
        frontend_switch_output, analog_regulator_on, analog_regulator_normal,
        low_voltage_regulator_on, bias_regulator_on, bias_regulator_normal}))
        else $error("state moved while frozen");
endmodule : ldo_decode_assertions

// ---- bench/host_pins.sv ----
// Purpose: Host side model that drives the control pins of the decode block.
// Assumes: The host moves its pins just after a rising clock edge.
// Notes:   Pin order follows the pin snapshot register.

`timescale 1ns/100ps

module host_pins (
    // Clock.
    input  wire logic       core_clk,
    // Requested levels, bit 0 master enable up to bit 4 secondary clock.
    input  wire logic [4:0] pins_req,
    // Pins toward the device.
    output logic            master_en,
    output logic            io_supply_present,
    output logic            chip_reset_n,
    output logic            radio_on_pin,
    output logic            secondary_clock_enable_pin
);
    logic [4:0] pins_q;

    // All pins start low, as on a host that has not powered its side yet.
    initial pins_q = 5'h00;

    // Registered so that pins never move in the sampling step of an edge.
    always @(posedge core_clk) begin
        pins_q <= pins_req;
    end

    assign {secondary_clock_enable_pin, radio_on_pin, chip_reset_n} = pins_q[4:2];
    assign {io_supply_present, master_en} = pins_q[1:0];
endmodule : host_pins

// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the regulator enable and mode decode.
// Assumes: Zero wait state APB slave; rails lag inputs by one edge.
// Notes:   Random pins and control words come from a fixed LFSR.

`timescale 1ns/100ps

module tb;
    import ldo_ctrl_pkg::*;

    logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata;
    logic me, io, crn, rad, sec, fe, rx_on, rx_n, an_on, an_n, lv_on, lv_n;
    logic [2:0] b_on, b_n;
    logic [4:0] pins_req = 5'h00;
    logic [4:0] p;
    logic [10:0] ctrl_m;
    logic [31:0] lfsr = 32'hc954, w;
    logic [32:0] exp_q[$], e_cur;
    int n_fail = 0, check_count = 0, cycles = 0;

    ldo_enable_mode_decode ldo_enable_mode_decode_inst (.core_clk(core_clk), .rst_n(rst_n),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .master_en(me), .io_supply_present(io), .chip_reset_n(crn), .radio_on_pin(rad),
        .secondary_clock_enable_pin(sec), .frontend_switch_output(fe),
        .receive_regulator_on(rx_on), .receive_regulator_normal(rx_n),
        .analog_regulator_on(an_on), .analog_regulator_normal(an_n),
        .low_voltage_regulator_on(lv_on), .low_voltage_regulator_normal(lv_n),
        .bias_regulator_on(b_on), .bias_regulator_normal(b_n));

    host_pins host_pins_inst (.core_clk(core_clk), .pins_req(pins_req), .master_en(me),
        .io_supply_present(io), .chip_reset_n(crn), .radio_on_pin(rad),
        .secondary_clock_enable_pin(sec));

    // Free running 125 MHz clock.
    initial begin
        forever #4 core_clk = ~core_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Reference decode from pin levels and control bits, laid out as STATUS.
    function automatic logic [12:0] decode(input logic [4:0] pn, input logic [10:0] c);
        logic [12:0] s;
        logic sup;
        sup = pn[0] & pn[1];
        s[0] = sup & pn[3] & c[1] & c[0];
        for (int i = 0; i < 3; i++) begin
            s[1+2*i] = sup & c[1+i];
            s[2+2*i] = s[1+2*i] & (!pn[2] | pn[3]);
            s[7+i] = pn[0] & c[4+i];
            s[10+i] = s[7+i] & (!pn[1] | (c[7] ? c[8+i] : pn[4]));
        end
        return s;
    endfunction : decode

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("mismatches %0d, comparisons %0d", n_fail, check_count);
        if (n_fail == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    // One APB transfer; the expected answer goes on the queue first.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the bench timeout may end this wait.
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    // Every answer is matched against the oldest queued expectation.
    always @(posedge core_clk) begin
        if (pready === 1'b1) begin
            e_cur = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1ffffffff;
            check({prdata, pslverr}, e_cur);
        end
    end

    // Guard against a hang; the whole run needs under two thousand cycles.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_fail++;
            complete_run();
        end
    end

    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        pins_req <= 5'h1f;
        repeat (3) @(posedge core_clk);
        ctrl_m = CTRL_RESET;
        apb(1'b0, CTRL_OFFSET, 32'h0, {21'h0, CTRL_RESET, 1'b0});
        apb(1'b1, 12'h00c, 32'hffffffff, 33'h1);
        apb(1'b0, 12'h010, 32'h0, 33'h1);
        apb(1'b1, STATUS_OFFSET, 32'h0, 33'h0);
        for (int i = 0; i < 60; i++) begin
            lfsr = lfsr_next(lfsr);
            p = {lfsr[4], lfsr[3], lfsr[5] | lfsr[6], lfsr[7] | lfsr[8], lfsr[9] | lfsr[10]};
            pins_req <= p;
            repeat (2) @(posedge core_clk);
            if (!p[0] || !p[2]) ctrl_m = CTRL_RESET;
            lfsr = lfsr_next(lfsr);
            w = {lfsr[15:0], lfsr[31:16]};
            apb(1'b1, CTRL_OFFSET, w, 33'h0);
            if (p[0] && p[2]) ctrl_m = w[10:0];
            repeat (3) @(posedge core_clk);
            check({20'h0, b_n, b_on, lv_n, lv_on, an_n, an_on, rx_n, rx_on, fe},
                  {20'h0, decode(p, ctrl_m)});
            apb(1'b0, STATUS_OFFSET, 32'h0, {19'h0, decode(p, ctrl_m), 1'b0});
            apb(1'b0, CTRL_OFFSET, 32'h0, {21'h0, ctrl_m, 1'b0});
            apb(1'b0, PINS_OFFSET, 32'h0, {27'h0, p, 1'b0});
        end
        // With the clock enable low, moving pins must not reach the rails.
        clk_en <= 1'b0;
        pins_req <= ~p;
        repeat (4) @(posedge core_clk);
        check({20'h0, b_n, b_on, lv_n, lv_on, an_n, an_on, rx_n, rx_on, fe},
              {20'h0, decode(p, ctrl_m)});
        pins_req <= p;
        repeat (2) @(posedge core_clk);
        clk_en <= 1'b1;
        repeat (3) @(posedge core_clk);
        complete_run();
    end
endmodule : tb

bind ldo_enable_mode_decode ldo_decode_assertions ldo_decode_assertions_inst (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pready(pready), .master_en(master_en), .io_supply_present(io_supply_present),
    .chip_reset_n(chip_reset_n), .radio_on_pin(radio_on_pin),
    .frontend_switch_output(frontend_switch_output),
    .receive_regulator_on(receive_regulator_on), .analog_regulator_on(analog_regulator_on),
    .analog_regulator_normal(analog_regulator_normal),
    .low_voltage_regulator_on(low_voltage_regulator_on),
    .low_voltage_regulator_normal(low_voltage_regulator_normal),
    .bias_regulator_on(bias_regulator_on), .bias_regulator_normal(bias_regulator_normal));
